/* File: ibau_addr_calc.sv */
// Purpose: Address arithmetic for indexed sums and bit-test branch targets.
// Assumes: idx, pc and rel are register outputs of the same clock; base carries the live bus read byte.
// Notes: Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`include "ibau_defines.svh"

module ibau_addr_calc (
   // Index operands
   input wire logic [7:0] idx,
   input wire logic [15:0] base,
   // Branch operands
   input wire logic [15:0] pc,
   input wire logic [7:0] rel,
   // Results
   output logic [15:0] index_sum,
   output logic [15:0] branch_sum
);

   logic [16:0] wide_sum;

   // full carry kept
   // The low-byte carry ripples into the high byte, so an 8-bit offset reaches 510.
   assign wide_sum = {9'h000, idx} + {1'b0, base};
   assign index_sum = wide_sum[15:0];

   // target after instruction
   // The offset is relative to the byte after the three-byte instruction.
   assign branch_sum = pc + {14'h0000, `IBAU_LEN_BTB} + {{8{rel[7]}}, rel};

endmodule : ibau_addr_calc

/* File: ibau_defines.svh */
// Purpose: Constants for the indexed and bit addressing unit.
// Assumes: Opcode high nibble selects the addressing mode.
// Notes: Definitions only; included by bare name.
`ifndef IBAU_DEFINES_SVH
`define IBAU_DEFINES_SVH

// Opcode high-nibble groups of the addressing modes handled here.
`define IBAU_GRP_BTB 4'h0
`define IBAU_GRP_BSC 4'h1
`define IBAU_GRP_INH_A 4'h4
`define IBAU_GRP_INH_X 4'h5
`define IBAU_GRP_IX1_RMW 4'h6
`define IBAU_GRP_INH_C1 4'h8
`define IBAU_GRP_INH_C2 4'h9
`define IBAU_GRP_IX2 4'hD
`define IBAU_GRP_IX1 4'hE

// Field positions inside the opcode for the bit modes.
`define IBAU_BIT_MSB 3
`define IBAU_BIT_LSB 1
`define IBAU_POL_BIT 0

// Instruction lengths in bytes.
`define IBAU_LEN_INH 2'h1
`define IBAU_LEN_IX1 2'h2
`define IBAU_LEN_BSC 2'h2
`define IBAU_LEN_IX2 2'h3
`define IBAU_LEN_BTB 2'h3
`define IBAU_LEN_NONE 2'h0

// Direct page high byte for bit modes.
`define IBAU_PAGE_ZERO 8'h00

`endif

/* File: ibau_mem_model.sv */
// Purpose: Memory bus partner for the addressing unit, with a set wait.
// Assumes: One request at a time, held until it is acknowledged.
// Notes: Read data outside an acknowledge shows the inverse of the last byte.
`timescale 1ns/10ps

module ibau_mem_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Memory bus
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   output logic bus_ack,
   // Wait states before each acknowledge
   input wire logic [3:0] wait_cyc
);
   logic [7:0] mem [0:65535];
   logic [3:0] cnt;
   logic [7:0] last;

   // A slow bus stretches every access by the same count.
   assign bus_ack = bus_req && (cnt == wait_cyc);
   // Idle data never repeats the last byte, so a stale sample is caught.
   assign bus_rdata = bus_ack ? mem[bus_addr] : ~last;

   // Wait counter restarts with every acknowledged access.
   always_ff @(posedge mclk) begin
      if (rst || !bus_req || bus_ack) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end

   // Read data is remembered at the acknowledge edge.
   always_ff @(posedge mclk) begin
      if (rst) begin
         last <= 8'h00;
      end else if (bus_ack) begin
         last <= mem[bus_addr];
      end
   end

   // Writes land at the acknowledge edge; a plain process, since the bench also preloads bytes.
   always @(posedge mclk) begin
      if (!rst && bus_ack && bus_we) begin
         mem[bus_addr] <= bus_wdata;
      end
   end
endmodule : ibau_mem_model

/* File: ibau_pkg.sv */
// Purpose: Types shared by the indexed and bit addressing unit.
// Assumes: Nothing beyond the defines header.
// Notes: Holds types only.
package ibau_pkg;

   // Addressing mode of the captured opcode.
   typedef enum logic [2:0] {
      ibau_mode_inh,
      ibau_mode_ix1,
      ibau_mode_ix2,
      ibau_mode_bsc,
      ibau_mode_btb,
      ibau_mode_other
   } ibau_mode_t;

   // Sequencer states.
   typedef enum logic [2:0] {
      ibau_st_idle,
      ibau_st_fetch1,
      ibau_st_fetch2,
      ibau_st_read,
      ibau_st_write,
      ibau_st_done
   } ibau_state_t;

endpackage : ibau_pkg

/* File: ibau_unit.sv */
// Purpose: Operand fetch and address generation for indexed, bit set/clear, bit test branch and inherent opcodes.
// Assumes: The memory bus answers each request with a one-cycle bus_ack.
// Notes: Other addressing modes finish at once with inst_len zero.
// Behaviour
// - 8-bit offset indexed address is index plus unsigned operand byte.
// - 8-bit offset indexed instruction is two bytes, reaching up to 510.
// - 16-bit offset indexed adds index to two-byte operand, three bytes long.
// - Bit set/clear takes bit from opcode, address from next byte.
// - Bit set/clear reaches any bit in lowest 256 locations, two bytes.
// - Bit test decodes bit and polarity from opcode, address from byte two.
// - Signed third byte added to PC only when tested bit matches.
// - Branch target spans -125 to +130 from opcode address.
// - Tested bit is always copied into carry.
// - Bit test and branch is three bytes, lowest 256 locations.
// - Inherent instructions are one byte with no operand fetch.
`timescale 1ns/10ps
`include "ibau_defines.svh"

module ibau_unit (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Instruction request
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [15:0] pc,
   input wire logic [7:0] idx,
   output logic busy,
   // Memory bus
   output logic bus_req,
   output logic bus_we,
   output logic [15:0] bus_addr,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_ack,
   // Results
   output logic done,
   output ibau_pkg::ibau_mode_t mode,
   output logic [15:0] ea,
   output logic [1:0] inst_len,
   output logic [15:0] next_pc,
   output logic branch_taken,
   output logic carry_we,
   output logic carry_val
);

   ibau_pkg::ibau_state_t state;
   logic [7:0] op_r;
   logic [15:0] pc_r;
   logic [7:0] idx_r;
   logic [7:0] op1_r;
   logic [7:0] op2_r;
   logic [7:0] data_r;
   logic [15:0] index_base;
   logic [15:0] index_sum;
   logic [15:0] branch_sum;
   logic [2:0] bit_num;
   logic tested_bit;

   // Opcode decode; the same table serves capture and checking.
   function automatic ibau_pkg::ibau_mode_t decode_mode(input logic [7:0] op);
      ibau_pkg::ibau_mode_t m;
      case (op[7:4])
         `IBAU_GRP_BTB: m = ibau_pkg::ibau_mode_btb;
         `IBAU_GRP_BSC: m = ibau_pkg::ibau_mode_bsc;
         `IBAU_GRP_INH_A, `IBAU_GRP_INH_X, `IBAU_GRP_INH_C1, `IBAU_GRP_INH_C2: m = ibau_pkg::ibau_mode_inh;
         `IBAU_GRP_IX1, `IBAU_GRP_IX1_RMW: m = ibau_pkg::ibau_mode_ix1;
         `IBAU_GRP_IX2: m = ibau_pkg::ibau_mode_ix2;
         default: m = ibau_pkg::ibau_mode_other;
      endcase
      return m;
   endfunction : decode_mode

   assign bit_num = op_r[`IBAU_BIT_MSB:`IBAU_BIT_LSB];
   assign tested_bit = bus_rdata[bit_num];

   // two-byte base
   // The high operand byte comes first, so it is already held when the low one lands.
   assign index_base = (mode == ibau_pkg::ibau_mode_ix2) ? {op1_r, bus_rdata} : {8'h00, bus_rdata};

   ibau_addr_calc u_calc (
      .idx(idx_r),
      .base(index_base),
      .pc(pc_r),
      .rel(op2_r),
      .index_sum(index_sum),
      .branch_sum(branch_sum)
   );

   // Handshake outputs decode the state register directly.
   assign busy = (state != ibau_pkg::ibau_st_idle);
   assign done = (state == ibau_pkg::ibau_st_done);
   assign bus_req = busy && !done;

   // Sequencer: operand bytes first, then the direct-page access for bit modes.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= ibau_pkg::ibau_st_idle;
      end else begin
         case (state)
            ibau_pkg::ibau_st_idle: begin
               if (start) begin
                  if ((decode_mode(opcode) == ibau_pkg::ibau_mode_inh) ||
                      (decode_mode(opcode) == ibau_pkg::ibau_mode_other)) begin
                     state <= ibau_pkg::ibau_st_done;
                  end else begin
                     state <= ibau_pkg::ibau_st_fetch1;
                  end
               end
            end
            ibau_pkg::ibau_st_fetch1: begin
               if (bus_ack) begin
                  case (mode)
                     ibau_pkg::ibau_mode_ix1: state <= ibau_pkg::ibau_st_done;
                     ibau_pkg::ibau_mode_bsc: state <= ibau_pkg::ibau_st_read;
                     default: state <= ibau_pkg::ibau_st_fetch2;
                  endcase
               end
            end
            ibau_pkg::ibau_st_fetch2: begin
               if (bus_ack) begin
                  state <= (mode == ibau_pkg::ibau_mode_btb) ? ibau_pkg::ibau_st_read : ibau_pkg::ibau_st_done;
               end
            end
            ibau_pkg::ibau_st_read: begin
               if (bus_ack) begin
                  state <= (mode == ibau_pkg::ibau_mode_bsc) ? ibau_pkg::ibau_st_write : ibau_pkg::ibau_st_done;
               end
            end
            ibau_pkg::ibau_st_write: begin
               if (bus_ack) begin
                  state <= ibau_pkg::ibau_st_done;
               end
            end
            ibau_pkg::ibau_st_done: begin
               state <= ibau_pkg::ibau_st_idle;
            end
            default: begin
               state <= ibau_pkg::ibau_st_idle;
            end
         endcase
      end
   end

   // Instruction capture; the request is only taken while idle.
   always_ff @(posedge mclk) begin
      if (rst) begin
         op_r <= 8'h00;
         pc_r <= 16'h0000;
         idx_r <= 8'h00;
         mode <= ibau_pkg::ibau_mode_inh;
      end else if (start && !busy) begin
         op_r <= opcode;
         pc_r <= pc;
         idx_r <= idx;
         mode <= decode_mode(opcode);
      end
   end

   // Operand and data bytes as they arrive.
   always_ff @(posedge mclk) begin
      if (rst) begin
         op1_r <= 8'h00;
         op2_r <= 8'h00;
         data_r <= 8'h00;
      end else if (bus_ack) begin
         if (state == ibau_pkg::ibau_st_fetch1) begin
            op1_r <= bus_rdata;
         end
         if (state == ibau_pkg::ibau_st_fetch2) begin
            op2_r <= bus_rdata;
         end
         if (state == ibau_pkg::ibau_st_read) begin
            data_r <= bus_rdata;
         end
      end
   end

   // Bus address and write data are registered one step ahead of each access.
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_addr <= 16'h0000;
         bus_we <= 1'b0;
         bus_wdata <= 8'h00;
      end else if (state == ibau_pkg::ibau_st_idle && start) begin
         bus_addr <= pc + 16'h0001;
         bus_we <= 1'b0;
      end else if (bus_ack) begin
         bus_we <= 1'b0;
         if (state == ibau_pkg::ibau_st_fetch1) begin
            if (mode == ibau_pkg::ibau_mode_bsc) begin
               bus_addr <= {`IBAU_PAGE_ZERO, bus_rdata};
            end else begin
               bus_addr <= pc_r + 16'h0002;
            end
         end else if (state == ibau_pkg::ibau_st_fetch2) begin
            bus_addr <= {`IBAU_PAGE_ZERO, op1_r};
         end else if (state == ibau_pkg::ibau_st_read && mode == ibau_pkg::ibau_mode_bsc) begin
            // modify one bit
            // Polarity bit low sets, high clears; all other bits are written back as read.
            bus_we <= 1'b1;
            bus_wdata <= bus_rdata;
            bus_wdata[bit_num] <= ~op_r[`IBAU_POL_BIT];
         end
      end
   end

   // Results are registered as the sequence enters its final state; bit set/clear registers them at the read acknowledge, before its write.
   always_ff @(posedge mclk) begin
      if (rst) begin
         ea <= 16'h0000;
         inst_len <= `IBAU_LEN_NONE;
         next_pc <= 16'h0000;
         branch_taken <= 1'b0;
         carry_we <= 1'b0;
         carry_val <= 1'b0;
      end else if (state == ibau_pkg::ibau_st_idle && start) begin
         inst_len <= (decode_mode(opcode) == ibau_pkg::ibau_mode_inh) ? `IBAU_LEN_INH : `IBAU_LEN_NONE;
         next_pc <= pc + ((decode_mode(opcode) == ibau_pkg::ibau_mode_inh) ? 16'h0001 : 16'h0000);
         ea <= 16'h0000;
         branch_taken <= 1'b0;
         carry_we <= 1'b0;
      end else if (bus_ack && state == ibau_pkg::ibau_st_fetch1 && mode == ibau_pkg::ibau_mode_ix1) begin
         ea <= index_sum;
         inst_len <= `IBAU_LEN_IX1;
         next_pc <= pc_r + {14'h0000, `IBAU_LEN_IX1};
      end else if (bus_ack && state == ibau_pkg::ibau_st_fetch2 && mode == ibau_pkg::ibau_mode_ix2) begin
         ea <= index_sum;
         inst_len <= `IBAU_LEN_IX2;
         next_pc <= pc_r + {14'h0000, `IBAU_LEN_IX2};
      end else if (bus_ack && state == ibau_pkg::ibau_st_read) begin
         ea <= {`IBAU_PAGE_ZERO, op1_r};
         if (mode == ibau_pkg::ibau_mode_bsc) begin
            inst_len <= `IBAU_LEN_BSC;
            next_pc <= pc_r + {14'h0000, `IBAU_LEN_BSC};
         end else begin
            carry_we <= 1'b1;
            carry_val <= tested_bit;
            inst_len <= `IBAU_LEN_BTB;
            // branch on match
            // Polarity bit low branches on a set bit, high on a clear bit.
            branch_taken <= (tested_bit != op_r[`IBAU_POL_BIT]);
            next_pc <= (tested_bit != op_r[`IBAU_POL_BIT]) ? branch_sum : pc_r + {14'h0000, `IBAU_LEN_BTB};
         end
      end else if (state == ibau_pkg::ibau_st_done) begin
         carry_we <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_start_inh;
      start && !busy && decode_mode(opcode) == ibau_pkg::ibau_mode_inh;
   endsequence
   sequence s_btb_done;
      done && mode == ibau_pkg::ibau_mode_btb;
   endsequence
   a_ix1_sum_check: assert property (done && mode == ibau_pkg::ibau_mode_ix1 |->
      ea == {8'h00, idx_r} + {8'h00, op1_r} && ea <= 16'h01FE && inst_len == 2'h2)
      else $error("8-bit indexed address or length wrong");
   a_ix2_sum_check: assert property (done && mode == ibau_pkg::ibau_mode_ix2 |->
      ea == {op1_r, op2_r} + {8'h00, idx_r} && inst_len == 2'h3)
      else $error("16-bit indexed address or length wrong");
   a_bsc_one_bit: assert property (bus_req && bus_we |->
      (bus_wdata ^ data_r) == ((8'h01 << bit_num) & (bus_wdata ^ data_r)) &&
      bus_wdata[bit_num] == ~op_r[0])
      else $error("Bit set/clear touched the wrong bit");
   a_bsc_page_zero: assert property ((state == ibau_pkg::ibau_st_read || state == ibau_pkg::ibau_st_write) |->
      bus_addr == {8'h00, op1_r})
      else $error("Bit access left the direct page");
   a_btb_carry_copy: assert property (s_btb_done |->
      carry_we && carry_val == data_r[bit_num] && $past(carry_we) == 1'b0)
      else $error("Tested bit not copied to carry");
   a_btb_branch_target: assert property (s_btb_done |->
      branch_taken == (data_r[bit_num] != op_r[0]) &&
      next_pc == (branch_taken ? pc_r + 16'h0003 + {{8{op2_r[7]}}, op2_r} : pc_r + 16'h0003))
      else $error("Bit-test branch target wrong");
   a_btb_three_bytes: assert property (s_btb_done |-> inst_len == 2'h3 &&
      ea[15:8] == 8'h00)
      else $error("Bit-test instruction length or page wrong");
   a_inh_no_fetch: assert property (s_start_inh |=> !bus_req && done ##1 !busy &&
      inst_len == 2'h1 && next_pc == pc_r + 16'h0001)
      else $error("Inherent instruction fetched an operand");
   a_ix_carry_kept: assert property (done && mode == ibau_pkg::ibau_mode_ix1 && idx_r[7] && op1_r[7] |->
      ea[8] == 1'b1)
      else $error("Indexed carry lost");
endmodule : ibau_unit

/* File: indexed_bit_addressing_unit_tb_top.sv */
// Purpose: Self-checking bench for the indexed and bit addressing unit.
// Assumes: Inputs change at the falling edge; the memory model answers the bus.
// Notes: Expected values are worked out here from opcode fields and operands.
`timescale 1ns/10ps

module indexed_bit_addressing_unit_tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [15:0] pc = 16'h0000;
   logic [7:0] idx = 8'h00;
   logic [3:0] wait_cyc = 4'h0;
   logic busy, bus_req, bus_we, bus_ack, done, branch_taken, carry_we, carry_val;
   logic [15:0] bus_addr, ea, next_pc;
   logic [7:0] bus_wdata, bus_rdata;
   logic [1:0] inst_len;
   ibau_pkg::ibau_mode_t mode;
   int bad_count = 0;
   int cmp_count = 0;
   int req_cycles;

   // Free-running 100 MHz clock.
   always #5 mclk = ~mclk;

   ibau_unit u_dut (.mclk(mclk), .rst(rst), .start(start), .opcode(opcode), .pc(pc), .idx(idx),
      .busy(busy), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .bus_ack(bus_ack), .done(done), .mode(mode), .ea(ea), .inst_len(inst_len),
      .next_pc(next_pc), .branch_taken(branch_taken), .carry_we(carry_we), .carry_val(carry_val));

   ibau_mem_model u_mem (.mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .wait_cyc(wait_cyc));

   // Compares one result value and counts it.
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("Counts: compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   // Issues one instruction and waits a bounded time for done, counting bus cycles.
   task automatic run_inst(input logic [7:0] op, input logic [15:0] p, input logic [7:0] x);
      int i;
      @(negedge mclk);
      opcode = op;
      pc = p;
      idx = x;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      req_cycles = 0;
      for (i = 0; i < 80 && done !== 1'b1; i++) begin
         req_cycles += (bus_req === 1'b1);
         @(negedge mclk);
      end
      check({15'h0000, done}, 16'h0001);
      if (done !== 1'b1) begin
         complete_run();
      end
   endtask : run_inst

   // One-byte instructions of every inherent group finish without any bus cycle.
   task automatic test_inherent();
      logic [7:0] ops [4] = '{8'h40, 8'h5F, 8'h80, 8'h9D};
      foreach (ops[k]) begin
         run_inst(ops[k], 16'h2000, 8'h33);
         check({14'h0000, inst_len}, 16'h0001);
         check(next_pc, 16'h2001);
         check(req_cycles[15:0], 16'h0000);
      end
      // An opcode outside the handled groups also ends at once, with no length and no bus cycle.
      run_inst(8'hA6, 16'h2200, 8'h00);
      check({14'h0000, inst_len}, 16'h0000);
      check(next_pc, 16'h2200);
      check(req_cycles[15:0], 16'h0000);
      check({13'h0000, mode}, {13'h0000, ibau_pkg::ibau_mode_other});
      $display("Test inherent finished");
   endtask : test_inherent

   // Byte offset plus index, including the 510 ceiling on a slow bus.
   task automatic test_ix1();
      u_mem.mem[16'h1001] = 8'h10;
      run_inst(8'h6A, 16'h1000, 8'h05);
      check(ea, 16'h0015);
      wait_cyc = 4'h3;
      u_mem.mem[16'h1001] = 8'hFF;
      run_inst(8'hE6, 16'h1000, 8'hFF);
      check(ea, 16'h01FE);
      check({14'h0000, inst_len}, 16'h0002);
      check(next_pc, 16'h1002);
      wait_cyc = 4'h0;
      $display("Test indexed byte offset finished");
   endtask : test_ix1

   // Two-byte offset, high byte first, with the index added in full.
   task automatic test_ix2();
      u_mem.mem[16'h3001] = 8'h12;
      u_mem.mem[16'h3002] = 8'h34;
      run_inst(8'hD6, 16'h3000, 8'hF0);
      check(ea, 16'h1324);
      check({14'h0000, inst_len}, 16'h0003);
      check(next_pc, 16'h3003);
      check({13'h0000, mode}, {13'h0000, ibau_pkg::ibau_mode_ix2});
      $display("Test indexed word offset finished");
   endtask : test_ix2

   // Every set and clear opcode changes only its own bit of a direct-page byte.
   task automatic test_bsc();
      logic [7:0] op, a, d, e;
      for (int n = 0; n < 16; n++) begin
         op = 8'h10 | n[7:0];
         a = 8'hF0 + n[7:0];
         d = 8'h5A;
         u_mem.mem[16'h5001] = a;
         u_mem.mem[{8'h00, a}] = d;
         run_inst(op, 16'h5000, 8'h00);
         e = op[0] ? (d & ~(8'h01 << op[3:1])) : (d | (8'h01 << op[3:1]));
         check({8'h00, u_mem.mem[{8'h00, a}]}, {8'h00, e});
         check(ea, {8'h00, a});
         check({14'h0000, inst_len}, 16'h0002);
      end
      $display("Test bit set clear finished");
   endtask : test_bsc

   // Every test opcode, both extreme offsets, taken and not taken, half on a slow bus.
   task automatic test_btb();
      logic [7:0] op, a, r, d;
      logic t, tk;
      for (int n = 0; n < 32; n++) begin
         op = {4'h0, n[3:0]};
         a = 8'hC0 + n[7:0];
         r = n[4] ? 8'h80 : 8'h7F;
         d = 8'hA5;
         wait_cyc = n[4] ? 4'h2 : 4'h0;
         u_mem.mem[16'h4001] = a;
         u_mem.mem[16'h4002] = r;
         u_mem.mem[{8'h00, a}] = d;
         run_inst(op, 16'h4000, 8'h00);
         t = d[op[3:1]];
         tk = t ^ op[0];
         check({15'h0000, carry_val}, {15'h0000, t});
         check({15'h0000, carry_we}, 16'h0001);
         check({15'h0000, branch_taken}, {15'h0000, tk});
         check(next_pc, tk ? 16'h4003 + {{8{r[7]}}, r} : 16'h4003);
         check(ea, {8'h00, a});
         check({14'h0000, inst_len}, 16'h0003);
      end
      wait_cyc = 4'h0;
      $display("Test bit test and branch finished");
   endtask : test_btb

   // Main sequence: reset for 12 cycles, then each scenario in turn.
   initial begin
      repeat (12) @(negedge mclk);
      check({15'h0000, busy}, 16'h0000);
      rst = 1'b0;
      test_inherent();
      test_ix1();
      test_ix2();
      test_bsc();
      test_btb();
      complete_run();
   end
endmodule : indexed_bit_addressing_unit_tb_top
